// [logic/pedsc_regs.svh]
// register offsets, field positions and masks of the port error detect block
`ifndef PEDSC_REGS_SVH
`define PEDSC_REGS_SVH

`define PEDSC_OFF_FLAGS 16'h2040
`define PEDSC_OFF_IRQ_STAT 16'h2050
`define PEDSC_OFF_IRQ_CLR 16'h2054
`define PEDSC_OFF_IRQ_EN 16'h2058
`define PEDSC_OFF_OWN_ID 16'h205c

`define PEDSC_BIT_VENDOR 31
`define PEDSC_BIT_SYM_CRC 22
`define PEDSC_BIT_SYM_ACK_SEQ 21
`define PEDSC_BIT_REFUSED_ACK 20
`define PEDSC_BIT_PKT_SEQ 19
`define PEDSC_BIT_PKT_CRC 18
`define PEDSC_BIT_OVERSIZE 17
`define PEDSC_BIT_STALE_ACK 5
`define PEDSC_BIT_PROTOCOL 4
`define PEDSC_BIT_DELINEATION 2
`define PEDSC_BIT_UNSOL_ACK 1
`define PEDSC_BIT_LINK_TIMEOUT 0

`define PEDSC_FLAGS_WMASK 32'h807e0037
`define PEDSC_FLAGS_RESET 32'h00000000
`define PEDSC_CAPT_MASK 32'h805e0012
`define PEDSC_OWN_ID_RESET 16'h0000
`define PEDSC_MAINT_FTYPE 4'h8

`endif

// [logic/pedsc_pkg.sv]
// types shared by the port error detect block
package pedsc_pkg;

  typedef struct packed {
    logic symbol_crc_fault;
    logic symbol_ack_sequence_fault;
    logic refused_packet_ack;
    logic packet_sequence_fault;
    logic packet_crc_fault;
    logic oversize_packet;
    logic stale_ack_response;
    logic protocol_fault;
    logic delineation_fault;
    logic unsolicited_ack;
    logic link_timeout;
    logic user_defined_interface_timeout;
  } pedsc_link_evt_t;

  typedef struct packed {
    logic [3:0] ftype;
    logic [3:0] ttype;
    logic [15:0] dest_id;
    logic large_id;
  } pedsc_pkt_hdr_t;

  typedef struct packed {
    logic illegal_maint;
    logic illegal_dest;
    logic unsupported;
  } pedsc_class_evt_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_IRQ_STAT,
    SEL_IRQ_CLR,
    SEL_IRQ_EN,
    SEL_OWN_ID
  } pedsc_sel_t;

endpackage : pedsc_pkg

// [logic/pedsc_classify.sv]
// header classifier: maintenance field, destination id and transaction type checks
`timescale 1ns/10ps
`include "pedsc_regs.svh"

module pedsc_classify #(
  parameter logic [15:0] MAINT_RSV_MASK = 16'hffe0,
  parameter logic [255:0] RSV_TTYPE_MAP = 256'h0
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic pkt_valid_i,
  input wire pedsc_pkg::pedsc_pkt_hdr_t pkt_hdr_i,
  input wire logic [15:0] own_id_i,
  output pedsc_pkg::pedsc_class_evt_t class_evt_o
);
  import pedsc_pkg::*;

  pedsc_class_evt_t evt_d;
  pedsc_class_evt_t evt_q;
  logic is_maint;
  logic [7:0] map_idx;

  always_comb begin
    is_maint = (pkt_hdr_i.ftype == `PEDSC_MAINT_FTYPE);
    map_idx = {pkt_hdr_i.ftype, pkt_hdr_i.ttype};
    evt_d = '0;
    if (pkt_valid_i) begin
      // maintenance ttypes are judged only by the maintenance table
      evt_d.illegal_maint = is_maint && MAINT_RSV_MASK[pkt_hdr_i.ttype];
      // small ids compare the low byte only
      if (pkt_hdr_i.large_id) begin
        evt_d.illegal_dest = (pkt_hdr_i.dest_id != own_id_i);
      end else begin
        evt_d.illegal_dest = (pkt_hdr_i.dest_id[7:0] != own_id_i[7:0]);
      end
      evt_d.unsupported = !is_maint && RSV_TTYPE_MAP[map_idx];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_q <= '0;
    end else begin
      evt_q <= evt_d;
    end
  end

  assign class_evt_o = evt_q;

endmodule : pedsc_classify

// [logic/pedsc_top.sv]
// port error detect flag register with interrupt and capture strobe
`timescale 1ns/10ps
`include "pedsc_regs.svh"

// Summary of operation
// - vendor flag bit 31 for listed faults
// - reserved maintenance ttype sets vendor flag
// - unsupported destination id sets vendor flag
// - reserved transaction ttype sets vendor flag
// - ingress interface timeout sets vendor flag
// - reserved bits read as zero
// - bit 22 on control symbol crc fault
// - bit 21 on unexpected ack ackid
// - no valid capture for ack ackid fault
// - bit 20 on packet-not-accepted symbol
// - bit 19 on packet ackid sequence fault
// - bit 18 on packet crc fault
// - bit 17 on oversize packet
// - bit 4 on unexpected packet or symbol
module pedsc_top #(
  parameter int ADDR_W = 16,
  parameter logic [15:0] MAINT_RSV_MASK = 16'hffe0,
  parameter logic [255:0] RSV_TTYPE_MAP = 256'h0
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire pedsc_pkg::pedsc_link_evt_t link_evt_i,
  input wire logic pkt_valid_i,
  input wire pedsc_pkg::pedsc_pkt_hdr_t pkt_hdr_i,
  output logic [31:0] flags_o,
  output logic capture_valid_o,
  output logic irq_o
);
  import pedsc_pkg::*;

  pedsc_class_evt_t class_evt;
  logic [31:0] evt_vec;
  logic [31:0] flags_d;
  logic [31:0] flags_q;
  logic [31:0] irq_stat_d;
  logic [31:0] irq_stat_q;
  logic [31:0] irq_en_d;
  logic [31:0] irq_en_q;
  logic [15:0] own_id_d;
  logic [15:0] own_id_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic capt_d;
  logic capt_q;
  pedsc_sel_t wr_sel;
  pedsc_sel_t rd_sel;

  function automatic pedsc_sel_t decode(input logic [ADDR_W-1:0] addr);
    pedsc_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_W'(`PEDSC_OFF_FLAGS)) begin
      sel = SEL_FLAGS;
    end else if (addr == ADDR_W'(`PEDSC_OFF_IRQ_STAT)) begin
      sel = SEL_IRQ_STAT;
    end else if (addr == ADDR_W'(`PEDSC_OFF_IRQ_CLR)) begin
      sel = SEL_IRQ_CLR;
    end else if (addr == ADDR_W'(`PEDSC_OFF_IRQ_EN)) begin
      sel = SEL_IRQ_EN;
    end else if (addr == ADDR_W'(`PEDSC_OFF_OWN_ID)) begin
      sel = SEL_OWN_ID;
    end
    return sel;
  endfunction : decode

  // one flag layout shared by detect flags and interrupt status
  function automatic logic [31:0] evt_to_vec(input pedsc_link_evt_t le,
                                             input pedsc_class_evt_t ce);
    logic [31:0] v;
    v = 32'h0;
    v[`PEDSC_BIT_VENDOR] = ce.illegal_maint | ce.illegal_dest | ce.unsupported
                           | le.user_defined_interface_timeout;
    v[`PEDSC_BIT_SYM_CRC] = le.symbol_crc_fault;
    v[`PEDSC_BIT_SYM_ACK_SEQ] = le.symbol_ack_sequence_fault;
    v[`PEDSC_BIT_REFUSED_ACK] = le.refused_packet_ack;
    v[`PEDSC_BIT_PKT_SEQ] = le.packet_sequence_fault;
    v[`PEDSC_BIT_PKT_CRC] = le.packet_crc_fault;
    v[`PEDSC_BIT_OVERSIZE] = le.oversize_packet;
    v[`PEDSC_BIT_STALE_ACK] = le.stale_ack_response;
    v[`PEDSC_BIT_PROTOCOL] = le.protocol_fault;
    v[`PEDSC_BIT_DELINEATION] = le.delineation_fault;
    v[`PEDSC_BIT_UNSOL_ACK] = le.unsolicited_ack;
    v[`PEDSC_BIT_LINK_TIMEOUT] = le.link_timeout;
    return v;
  endfunction : evt_to_vec

  pedsc_classify #(
    .MAINT_RSV_MASK(MAINT_RSV_MASK),
    .RSV_TTYPE_MAP(RSV_TTYPE_MAP)
  ) u_classify (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .pkt_valid_i(pkt_valid_i),
    .pkt_hdr_i(pkt_hdr_i),
    .own_id_i(own_id_q),
    .class_evt_o(class_evt)
  );

  always_comb begin
    evt_vec = evt_to_vec(link_evt_i, class_evt);
    wr_sel = reg_wr_i ? decode(reg_addr_i) : SEL_NONE;
    rd_sel = reg_rd_i ? decode(reg_addr_i) : SEL_NONE;
  end

  // register state; hardware events are ORed in last so a set beats a clear
  always_comb begin
    flags_d = flags_q;
    irq_stat_d = irq_stat_q;
    irq_en_d = irq_en_q;
    own_id_d = own_id_q;
    if (wr_sel == SEL_FLAGS) begin
      flags_d = reg_wdata_i & `PEDSC_FLAGS_WMASK;
    end
    if (wr_sel == SEL_IRQ_CLR) begin
      irq_stat_d = irq_stat_q & ~reg_wdata_i;
    end
    if (wr_sel == SEL_IRQ_EN) begin
      irq_en_d = reg_wdata_i & `PEDSC_FLAGS_WMASK;
    end
    if (wr_sel == SEL_OWN_ID) begin
      own_id_d = reg_wdata_i[15:0];
    end
    flags_d = flags_d | evt_vec;
    irq_stat_d = irq_stat_d | evt_vec;
  end

  // capture strobe is withheld for faults whose capture data are not valid
  always_comb begin
    capt_d = |(evt_vec & `PEDSC_CAPT_MASK);
  end

  always_comb begin
    rdata_d = 32'h0;
    if (rd_sel == SEL_FLAGS) begin
      rdata_d = flags_q & `PEDSC_FLAGS_WMASK;
    end else if (rd_sel == SEL_IRQ_STAT) begin
      rdata_d = irq_stat_q;
    end else if (rd_sel == SEL_IRQ_EN) begin
      rdata_d = irq_en_q;
    end else if (rd_sel == SEL_OWN_ID) begin
      rdata_d = {16'h0, own_id_q};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= `PEDSC_FLAGS_RESET;
      irq_stat_q <= 32'h0;
      irq_en_q <= 32'h0;
      own_id_q <= `PEDSC_OWN_ID_RESET;
      rdata_q <= 32'h0;
      capt_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      own_id_q <= own_id_d;
      rdata_q <= rdata_d;
      capt_q <= capt_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign flags_o = flags_q;
  assign capture_valid_o = capt_q;
  assign irq_o = |(irq_stat_q & irq_en_q);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_vendor_timeout;
    link_evt_i.user_defined_interface_timeout |=> flags_q[`PEDSC_BIT_VENDOR];
  endproperty
  a_vendor_timeout: assert property (p_vendor_timeout) else $error("timeout not flagged");

  property p_vendor_maint;
    pkt_valid_i && pkt_hdr_i.ftype == `PEDSC_MAINT_FTYPE && MAINT_RSV_MASK[pkt_hdr_i.ttype]
      |-> ##2 flags_q[`PEDSC_BIT_VENDOR];
  endproperty
  a_vendor_maint: assert property (p_vendor_maint) else $error("maint field not flagged");

  property p_vendor_dest;
    pkt_valid_i && pkt_hdr_i.large_id && pkt_hdr_i.dest_id != own_id_q
      && !(wr_sel == SEL_OWN_ID) |-> ##2 flags_q[`PEDSC_BIT_VENDOR];
  endproperty
  a_vendor_dest: assert property (p_vendor_dest) else $error("dest id not flagged");

  property p_vendor_unsup;
    pkt_valid_i && pkt_hdr_i.ftype != `PEDSC_MAINT_FTYPE
      && RSV_TTYPE_MAP[{pkt_hdr_i.ftype, pkt_hdr_i.ttype}] |-> ##2 flags_q[`PEDSC_BIT_VENDOR];
  endproperty
  a_vendor_unsup: assert property (p_vendor_unsup) else $error("ttype not flagged");

  property p_sym_crc;
    link_evt_i.symbol_crc_fault |=> flags_q[`PEDSC_BIT_SYM_CRC];
  endproperty
  a_sym_crc: assert property (p_sym_crc) else $error("symbol crc not flagged");

  property p_sym_ack;
    link_evt_i.symbol_ack_sequence_fault |=> flags_q[`PEDSC_BIT_SYM_ACK_SEQ];
  endproperty
  a_sym_ack: assert property (p_sym_ack) else $error("symbol ackid not flagged");

  property p_no_capt;
    (evt_vec & `PEDSC_CAPT_MASK) == 32'h0 |=> !capture_valid_o;
  endproperty
  a_no_capt: assert property (p_no_capt) else $error("capture strobe without valid data");

  property p_refused;
    link_evt_i.refused_packet_ack |=> flags_q[`PEDSC_BIT_REFUSED_ACK];
  endproperty
  a_refused: assert property (p_refused) else $error("refused ack not flagged");

  property p_pkt_seq;
    link_evt_i.packet_sequence_fault |=> flags_q[`PEDSC_BIT_PKT_SEQ];
  endproperty
  a_pkt_seq: assert property (p_pkt_seq) else $error("packet ackid not flagged");

  property p_pkt_crc;
    link_evt_i.packet_crc_fault |=> flags_q[`PEDSC_BIT_PKT_CRC];
  endproperty
  a_pkt_crc: assert property (p_pkt_crc) else $error("packet crc not flagged");

  property p_oversize;
    link_evt_i.oversize_packet |=> flags_q[`PEDSC_BIT_OVERSIZE];
  endproperty
  a_oversize: assert property (p_oversize) else $error("oversize not flagged");

  property p_protocol;
    link_evt_i.protocol_fault |=> flags_q[`PEDSC_BIT_PROTOCOL];
  endproperty
  a_protocol: assert property (p_protocol) else $error("protocol fault not flagged");

  property p_rsv_zero;
    rd_sel == SEL_FLAGS |=> (reg_rdata_o & ~`PEDSC_FLAGS_WMASK) == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_sticky;
    flags_q[`PEDSC_BIT_PKT_CRC] && wr_sel != SEL_FLAGS |=> flags_q[`PEDSC_BIT_PKT_CRC];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_sw_write;
    wr_sel == SEL_FLAGS && evt_vec == 32'h0
      |=> flags_q == ($past(reg_wdata_i) & `PEDSC_FLAGS_WMASK);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software write not stored");

  property p_irq;
    link_evt_i.packet_crc_fault && irq_en_q[`PEDSC_BIT_PKT_CRC] && wr_sel != SEL_IRQ_EN
      |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled event raised no interrupt");

  c_clear_flag: cover property (flags_q[`PEDSC_BIT_SYM_CRC] ##1 !flags_q[`PEDSC_BIT_SYM_CRC]);
  c_set_beats_clear: cover property (wr_sel == SEL_FLAGS && evt_vec != 32'h0);
  c_irq_then_clear: cover property (irq_o ##1 wr_sel == SEL_IRQ_CLR ##1 !irq_o);
  c_vendor_from_pkt: cover property (class_evt != '0 ##1 flags_q[`PEDSC_BIT_VENDOR]);

endmodule : pedsc_top

// [tb/pedsc_link_partner.sv]
// link partner model: event pulses and received headers on request
`timescale 1ns/10ps
module pedsc_link_partner (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire pedsc_pkg::pedsc_link_evt_t evt_cmd_i,
  input wire logic pkt_cmd_i,
  input wire pedsc_pkg::pedsc_pkt_hdr_t hdr_cmd_i,
  output pedsc_pkg::pedsc_link_evt_t link_evt_o,
  output logic pkt_valid_o,
  output pedsc_pkg::pedsc_pkt_hdr_t pkt_hdr_o
);
  import pedsc_pkg::*;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_evt_o <= '0;
      pkt_valid_o <= 1'b0;
      pkt_hdr_o <= '0;
    end else begin
      link_evt_o <= evt_cmd_i;
      pkt_valid_o <= pkt_cmd_i;
      // header lines keep toggling outside a valid cycle so stale data is never taken
      pkt_hdr_o <= pkt_cmd_i ? hdr_cmd_i : ~pkt_hdr_o;
    end
  end
endmodule : pedsc_link_partner

// [tb/testbench.sv]
// self-checking bench of the port error detect block
`timescale 1ns/10ps
`include "pedsc_regs.svh"
module testbench;
  import pedsc_pkg::*;
  logic sys_clk_i;
  logic rstn_i;
  logic [15:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, flags_o;
  logic reg_wr_i, reg_rd_i, capture_valid_o, irq_o, pkt_cmd, pkt_valid;
  pedsc_link_evt_t link_evt, evt_cmd;
  pedsc_pkt_hdr_t pkt_hdr, hdr_cmd;
  int n_errors = 0;
  int comparisons = 0;
  int cap_cnt = 0;
  int evt_bit [12] = '{31, 0, 1, 2, 4, 5, 17, 18, 19, 20, 21, 22};
  logic [24:0] hdr_tab [7] = '{{4'h8, 4'h5, 16'h0012, 1'b0}, {4'h8, 4'h0, 16'h0012, 1'b0},
    {4'h2, 4'h4, 16'h0034, 1'b0}, {4'h2, 4'h4, 16'hab12, 1'b0}, {4'h2, 4'h4, 16'hab12, 1'b1},
    {4'h5, 4'hc, 16'h0012, 1'b0}, {4'h5, 4'hb, 16'h0012, 1'b0}};
  logic [6:0] vend_exp = 7'b0110101;

  pedsc_link_partner partner (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .evt_cmd_i(evt_cmd),
    .pkt_cmd_i(pkt_cmd), .hdr_cmd_i(hdr_cmd), .link_evt_o(link_evt), .pkt_valid_o(pkt_valid),
    .pkt_hdr_o(pkt_hdr));

  // one reserved ttype slot so the unsupported path is reachable
  pedsc_top #(.RSV_TTYPE_MAP(256'h1 << 8'h5c)) dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link_evt_i(link_evt),
    .pkt_valid_i(pkt_valid), .pkt_hdr_i(pkt_hdr), .flags_o(flags_o),
    .capture_valid_o(capture_valid_o), .irq_o(irq_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (capture_valid_o === 1'b1) begin
      cap_cnt <= cap_cnt + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, exp);
  endtask : rdc

  task automatic fire(input logic [11:0] e);
    @(posedge sys_clk_i);
    evt_cmd <= e;
    @(posedge sys_clk_i);
    evt_cmd <= '0;
    repeat (3) @(posedge sys_clk_i);
  endtask : fire

  task automatic send(input logic [24:0] h);
    @(posedge sys_clk_i);
    hdr_cmd <= h;
    pkt_cmd <= 1'b1;
    @(posedge sys_clk_i);
    pkt_cmd <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : send

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #250000;
    n_errors++;
    end_of_test();
  end

  initial begin
    int c;
    logic [31:0] m;
    logic [11:0] e;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    evt_cmd = '0;
    pkt_cmd = 1'b0;
    hdr_cmd = '0;
    rstn_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(negedge sys_clk_i);
    chk(flags_o | {31'h0, irq_o}, 32'h0);
    rdc(`PEDSC_OFF_FLAGS, 32'h0);
    wr(`PEDSC_OFF_FLAGS, 32'hffffffff);
    rdc(`PEDSC_OFF_FLAGS, `PEDSC_FLAGS_WMASK);
    // read data stand for one cycle only, then fall back to zero
    @(negedge sys_clk_i);
    chk(reg_rdata_o, 32'h0);
    wr(`PEDSC_OFF_FLAGS, 32'h0);
    rdc(`PEDSC_OFF_FLAGS, 32'h0);
    wr(16'h2044, 32'hffffffff);
    rdc(16'h2044, 32'h0);
    rdc(`PEDSC_OFF_IRQ_CLR, 32'h0);
    $display("test registers done");
    wr(`PEDSC_OFF_IRQ_EN, 32'hffffffff);
    rdc(`PEDSC_OFF_IRQ_EN, `PEDSC_FLAGS_WMASK);
    for (int i = 0; i < 12; i++) begin
      e = 12'h1 << i;
      m = 32'h1 << evt_bit[i];
      c = cap_cnt;
      fire(e);
      repeat (6) @(posedge sys_clk_i);
      rdc(`PEDSC_OFF_FLAGS, m);
      chk(flags_o, m);
      chk({31'h0, irq_o}, 32'h1);
      chk(((cap_cnt - c) != 0) ? m : 32'h0, `PEDSC_CAPT_MASK & m);
      rdc(`PEDSC_OFF_IRQ_STAT, m);
      wr(`PEDSC_OFF_FLAGS, 32'h0);
      wr(`PEDSC_OFF_IRQ_CLR, m);
      rdc(`PEDSC_OFF_FLAGS, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
    end
    $display("test link events done");
    wr(`PEDSC_OFF_IRQ_EN, 32'h0);
    fire(12'h080);
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rdc(`PEDSC_OFF_IRQ_STAT, 32'h00040000);
    wr(`PEDSC_OFF_IRQ_EN, 32'h00040000);
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(`PEDSC_OFF_IRQ_CLR, 32'hffffffff);
    wr(`PEDSC_OFF_FLAGS, 32'h0);
    $display("test interrupt mask done");
    // clearing write lands on the same edge as the event: the event must win
    fork
      fire(12'h080);
      begin
        @(posedge sys_clk_i);
        wr(`PEDSC_OFF_FLAGS, 32'h0);
      end
    join
    rdc(`PEDSC_OFF_FLAGS, 32'h00040000);
    wr(`PEDSC_OFF_FLAGS, 32'h0);
    rdc(`PEDSC_OFF_FLAGS, 32'h0);
    $display("test set beats clear done");
    wr(`PEDSC_OFF_OWN_ID, 32'h00000012);
    rdc(`PEDSC_OFF_OWN_ID, 32'h00000012);
    for (int i = 0; i < 7; i++) begin
      send(hdr_tab[i]);
      rdc(`PEDSC_OFF_FLAGS, {vend_exp[i], 31'h0});
      wr(`PEDSC_OFF_FLAGS, 32'h0);
    end
    $display("test header classes done");
    end_of_test();
  end
endmodule : testbench
